// ===== eei_pkg.sv
// Package with register map, field positions and timing constants for the edge interrupt block.
package eei_pkg;
    // Register byte addresses on the APB bus.
    localparam logic [7:0] EEI_CTRL_ADDR = 8'h00;
    localparam logic [7:0] EEI_CFG_ADDR = 8'h04;
    localparam logic [7:0] EEI_STAT_ADDR = 8'h08;
    localparam logic [7:0] EEI_CORE_ADDR = 8'h0C;
    // Field positions in ext_and_global_irq_ctrl.
    localparam int EEI_GLOBAL_EN_BIT = 7;
    localparam int EEI_PERIPH_EN_BIT = 6;
    localparam int EEI_TIMER0_EN_BIT = 5;
    localparam int EEI_PIN_EN_BIT = 4;
    localparam int EEI_CHANGE_EN_BIT = 3;
    localparam int EEI_TIMER0_FLAG_BIT = 2;
    localparam int EEI_PIN_FLAG_BIT = 1;
    localparam int EEI_CHANGE_FLAG_BIT = 0;
    // Field positions in the configuration register.
    localparam int EEI_EDGE_BIT = 0;
    localparam int EEI_ANALOG_BIT = 1;
    // Reset values.
    localparam logic [7:0] EEI_CTRL_RST = 8'h00;
    localparam logic [1:0] EEI_CFG_RST = 2'b10;
    // Service vector loaded into the program counter.
    localparam logic [12:0] EEI_VECTOR = 13'h0004;
    // Instruction cycle is four clock phases.
    localparam int EEI_PHASES = 4;
    // Phase numbers of the instruction cycle.
    typedef enum logic [1:0] {EEI_Q1, EEI_Q2, EEI_Q3, EEI_Q4} eei_phase_t;
endpackage : eei_pkg

// ===== eei_if.sv
// Interface carrying the synchronised pin edge from detector to controller.
`timescale 1ns/100ps
interface eei_edge_if;
    logic pinLevel;
    logic edgeSeen;
    modport det (output pinLevel, output edgeSeen);
    modport ctl (input pinLevel, input edgeSeen);
endinterface : eei_edge_if

// ===== eei_edge_det.sv
// Synchroniser and polarity selected edge detector for the external interrupt pin.
`timescale 1ns/100ps
module eei_edge_det
    import eei_pkg::*;
(
    input wire logic clk,          // Core clock.
    input wire logic reset_n,      // Asynchronous reset, active low.
    input wire logic extIrqPin,    // Raw pin level.
    input wire logic risingSel,    // One selects rising edge.
    input wire logic analogSel,    // One makes the pin analog.
    eei_edge_if.det edgeBus        // Level and edge to the controller.
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic digital;

    // Two stage synchroniser; only the second stage is read by logic.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= extIrqPin;
            sync2_q <= sync1_q;
        end
    end

    // Analog pins read as zero, so once held analog they can never make an edge.
    assign digital = sync2_q & ~analogSel; // [RULE6]

    // Previous sample for edge comparison.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            prev_q <= 1'b0;
        else
            prev_q <= digital; // [RULE11]
    end

    assign edgeBus.pinLevel = digital;
    // Rising when select is one, falling when zero.
    assign edgeBus.edgeSeen = risingSel ? (digital & ~prev_q)
                                        : (~digital & prev_q); // [RULE1]
endmodule : eei_edge_det

// ===== external_edge_interrupt.sv
// External pin edge interrupt controller with APB register access.
// Functional notes
// [RULE1] The pin interrupt fires on a rising edge when polarity select is one, else falling.
// [RULE2] A valid edge of the selected polarity sets the pin interrupt flag.
// [RULE3] With the pin interrupt enable clear no request is raised from the flag.
// [RULE4] Software clears the flag before re-enabling; hardware never clears it.
// [RULE5] A valid edge wakes the core from sleep if the enable was set before sleep.
// [RULE6] An analog-configured pin reads zero and never interrupts; the switch to analog with the pin high and falling polarity sets the flag.
// [RULE7] The flag may be set during phases Q4 through Q1 of the instruction cycle.
// [RULE8] The flag is set regardless of its enable and of the global enable.
// [RULE9] Servicing clears the global enable, pushes the return address, loads vector 0004h.
// [RULE10] Service begins three or four instruction cycles after the pin event.
// [RULE11] The pin is synchronised and compared with its last sample; request needs all enables.
`timescale 1ns/100ps
module external_edge_interrupt
    import eei_pkg::*;
(
    input wire logic clk,              // 20 MHz core clock.
    input wire logic reset_n,          // Asynchronous reset, active low.
    input wire logic extIrqPin,        // External interrupt pin.
    input wire logic sleepReq,         // Core enters sleep, one-cycle pulse.
    input wire logic retFromIrq,       // Return from irq instruction retired, pulse.
    input wire logic [12:0] curPc,     // Return address to push.
    input wire logic psel,             // APB select.
    input wire logic penable,          // APB enable.
    input wire logic pwrite,           // APB direction.
    input wire logic [7:0] paddr,      // APB byte address.
    input wire logic [31:0] pwdata,    // APB write data.
    output logic [31:0] prdata,        // APB read data.
    output logic pready,               // APB ready.
    output logic pslverr,              // APB error on unmapped address.
    output logic irqReq,               // Request: flag, enable and global all set.
    output logic asleep,               // Core is sleeping.
    output logic wakeUp,               // Wake pulse out of sleep.
    output logic serviceStart,         // Pulse: vector load now.
    output logic [12:0] pcLoad,        // Vector for program counter.
    output logic [12:0] pushAddr       // Return address pushed.
);
    logic [7:0] ctrl_q;
    logic [1:0] cfg_q;
    logic asleep_q;
    logic wakeUp_q;
    logic enAtSleep_q;
    logic pendEdge_q;
    logic serviceStart_q;
    logic [12:0] pushAddr_q;
    logic [1:0] phase_q;
    logic [2:0] latCnt_q;
    logic latBusy_q;
    logic wrCtrl;
    logic setWindow;
    logic setFlag;
    logic accessEn;
    logic mapped;
    eei_edge_if edgeBus ();

    // Edge detection lives in its own module to keep the synchroniser self-contained.
    eei_edge_det uDet (
        .clk       (clk),
        .reset_n   (reset_n),
        .extIrqPin (extIrqPin),
        .risingSel (cfg_q[EEI_EDGE_BIT]),
        .analogSel (cfg_q[EEI_ANALOG_BIT]),
        .edgeBus   (edgeBus)
    );

    // Address decode used only for the error response; read and write paths decode paddr themselves.
    function automatic logic eei_mapped(input logic [7:0] a);
        eei_mapped = (a == EEI_CTRL_ADDR) || (a == EEI_CFG_ADDR) ||
                     (a == EEI_STAT_ADDR) || (a == EEI_CORE_ADDR);
    endfunction : eei_mapped

    // Zero wait state slave: the access phase completes in one cycle.
    assign accessEn = psel & penable;
    assign mapped = eei_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = accessEn & ~mapped;
    assign wrCtrl = accessEn & pwrite & (paddr == EEI_CTRL_ADDR);

    // Instruction phase counter, Q1..Q4 of each instruction cycle.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            phase_q <= 2'd0;
        else
            phase_q <= phase_q + 2'd1;
    end

    // Flag may be set only in Q4 or Q1; edges elsewhere wait for the window.
    assign setWindow = (phase_q == 2'(EEI_Q4)) || (phase_q == 2'(EEI_Q1)); // [RULE7]

    // Edges seen outside the window are held until it opens.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pendEdge_q <= 1'b0;
        else if (setWindow)
            pendEdge_q <= 1'b0;
        else if (edgeBus.edgeSeen)
            pendEdge_q <= 1'b1;
    end

    // Set regardless of enables.
    assign setFlag = setWindow & (edgeBus.edgeSeen | pendEdge_q); // [RULE2] [RULE8]

    // Control register; set of the flag wins over a software clear in the same cycle.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_q <= EEI_CTRL_RST;
        else
        begin
            if (wrCtrl)
                ctrl_q <= pwdata[7:0];
            if (serviceStart_q)
                ctrl_q[EEI_GLOBAL_EN_BIT] <= 1'b0; // [RULE9]
            else if (retFromIrq)
                ctrl_q[EEI_GLOBAL_EN_BIT] <= 1'b1;
            if (setFlag)
                ctrl_q[EEI_PIN_FLAG_BIT] <= 1'b1; // [RULE2] [RULE4]
        end
    end

    // Configuration register: polarity select and analog select.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cfg_q <= EEI_CFG_RST;
        else if (accessEn && pwrite && paddr == EEI_CFG_ADDR)
            cfg_q <= pwdata[1:0];
    end

    // Request needs the flag, the local enable and the global enable.
    assign irqReq = ctrl_q[EEI_PIN_FLAG_BIT] & ctrl_q[EEI_PIN_EN_BIT]
                    & ctrl_q[EEI_GLOBAL_EN_BIT]; // [RULE3] [RULE11]

    // Sleep state; enable is captured on entry so a later set does not wake.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            asleep_q <= 1'b0;
            enAtSleep_q <= 1'b0;
            wakeUp_q <= 1'b0;
        end
        else
        begin
            wakeUp_q <= 1'b0;
            if (sleepReq && !asleep_q)
            begin
                asleep_q <= 1'b1;
                enAtSleep_q <= ctrl_q[EEI_PIN_EN_BIT];
            end
            else if (asleep_q && setFlag && enAtSleep_q)
            begin
                asleep_q <= 1'b0; // [RULE5]
                wakeUp_q <= 1'b1;
            end
        end
    end

    // Latency counter: service starts three instruction cycles after the request.
    // The flag lands in Q4 or Q1, so the total from the pin is three or four cycles.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            latBusy_q <= 1'b0;
            latCnt_q <= 3'd0;
            serviceStart_q <= 1'b0;
            pushAddr_q <= 13'h0000;
        end
        else
        begin
            serviceStart_q <= 1'b0;
            if (!latBusy_q && irqReq && !asleep_q && !serviceStart_q)
            begin
                latBusy_q <= 1'b1;
                latCnt_q <= 3'd0;
            end
            else if (latBusy_q && phase_q == 2'(EEI_Q4))
            begin
                if (latCnt_q == 3'd2)
                begin
                    latBusy_q <= 1'b0;
                    serviceStart_q <= 1'b1; // [RULE10]
                    pushAddr_q <= curPc; // [RULE9]
                end
                else
                    latCnt_q <= latCnt_q + 3'd1;
            end
        end
    end

    // Read mux; unused upper bits read as zero.
    always_comb
    begin
        prdata = 32'h0000_0000;
        case (paddr)
            EEI_CTRL_ADDR: prdata[7:0] = ctrl_q;
            EEI_CFG_ADDR: prdata[1:0] = cfg_q;
            EEI_STAT_ADDR: prdata[1:0] = {asleep_q, edgeBus.pinLevel}; // [RULE6]
            EEI_CORE_ADDR: prdata[12:0] = pushAddr_q;
            default: prdata = 32'h0000_0000;
        endcase
    end

    assign asleep = asleep_q;
    assign wakeUp = wakeUp_q;
    assign serviceStart = serviceStart_q;
    assign pcLoad = EEI_VECTOR; // [RULE9]
    assign pushAddr = pushAddr_q;

    // Assertions guarding the interrupt behaviour.
    // Named steps shared by the flag and sleep properties below.
    sequence s_flagSet;
        setFlag;
    endsequence

    sequence s_sleepArmed;
        asleep_q && enAtSleep_q;
    endsequence

    sequence s_sleepMasked;
        asleep_q && !enAtSleep_q;
    endsequence

    // A set in the window must leave the flag up on the next cycle.
    a_flag_sets: assert property (@(posedge clk) disable iff (!reset_n)
        s_flagSet |=> ctrl_q[EEI_PIN_FLAG_BIT]) // [RULE2]
        else $error("flag not set after edge");

    // Hardware may raise the flag only out of a Q4 or Q1 cycle; software writes are exempt.
    a_flag_window: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(ctrl_q[EEI_PIN_FLAG_BIT]) && !$past(wrCtrl) |-> $past(setWindow)) // [RULE7]
        else $error("flag set outside Q4-Q1");

    // Only a software write may take the flag down.
    a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_q[EEI_PIN_FLAG_BIT] && !wrCtrl |=> ctrl_q[EEI_PIN_FLAG_BIT]) // [RULE4]
        else $error("flag cleared by hardware");

    // A software clear lands when no edge competes with it.
    a_sw_clear: assert property (@(posedge clk) disable iff (!reset_n)
        wrCtrl && !pwdata[EEI_PIN_FLAG_BIT] && !setFlag |=> !ctrl_q[EEI_PIN_FLAG_BIT]) // [RULE4]
        else $error("software clear of flag lost");

    // No request may leave the block while the local enable is clear.
    a_req_gated: assert property (@(posedge clk) disable iff (!reset_n)
        !ctrl_q[EEI_PIN_EN_BIT] |-> !irqReq) // [RULE3]
        else $error("request with enable clear");

    // Servicing drops the global enable so no second request follows at once.
    a_global_clear: assert property (@(posedge clk) disable iff (!reset_n)
        serviceStart |=> !ctrl_q[EEI_GLOBAL_EN_BIT]) // [RULE9]
        else $error("global enable not cleared on service");

    // The pushed address is the one presented on the Q4 cycle before the service pulse.
    a_push_addr: assert property (@(posedge clk) disable iff (!reset_n)
        serviceStart |-> pushAddr == $past(curPc)) // [RULE9]
        else $error("wrong return address pushed");

    // An armed sleep ends on the first flag set.
    a_wake_edge: assert property (@(posedge clk) disable iff (!reset_n)
        s_sleepArmed ##0 s_flagSet |=> wakeUp && !asleep) // [RULE5]
        else $error("no wake on edge");

    // A sleep entered with the enable clear never wakes on the pin.
    a_masked_sleep: assert property (@(posedge clk) disable iff (!reset_n)
        s_sleepMasked |=> !wakeUp) // [RULE5]
        else $error("wake with enable clear at sleep");

    // Every wake pulse must come from an armed sleep.
    a_wake_armed: assert property (@(posedge clk) disable iff (!reset_n)
        wakeUp |-> $past(enAtSleep_q)) // [RULE5]
        else $error("wake without armed sleep");

    // A pin held analog makes no edge.
    a_analog_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_q[EEI_ANALOG_BIT] && $past(cfg_q[EEI_ANALOG_BIT]) |-> !edgeBus.edgeSeen) // [RULE6]
        else $error("analog pin made an edge");

    // A pin held analog reads as zero.
    a_analog_level: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_q[EEI_ANALOG_BIT] |-> !edgeBus.pinLevel) // [RULE6]
        else $error("analog pin reads nonzero");

    // An edge is reported only when the new level matches the chosen polarity.
    a_edge_polarity: assert property (@(posedge clk) disable iff (!reset_n)
        edgeBus.edgeSeen |-> edgeBus.pinLevel == cfg_q[EEI_EDGE_BIT]) // [RULE1]
        else $error("edge of wrong polarity");

    // An edge reaches the flag within the next set window, never dropped.
    a_edge_flag: assert property (@(posedge clk) disable iff (!reset_n)
        edgeBus.edgeSeen |-> ##[0:2] setFlag) // [RULE2]
        else $error("edge never reached the flag");

    // Edges outside the window are held until it opens.
    a_pend_held: assert property (@(posedge clk) disable iff (!reset_n)
        edgeBus.edgeSeen && !setWindow |=> pendEdge_q) // [RULE7]
        else $error("edge outside window lost");

    // Service follows the request within the three instruction cycle budget.
    a_latency_bound: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(latBusy_q) |-> ##[9:12] serviceStart) // [RULE10]
        else $error("service latency out of range");

    // Service starts on an instruction boundary, after a Q4 cycle.
    a_service_q4: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(serviceStart) |-> $past(phase_q) == 2'(EEI_Q4)) // [RULE10]
        else $error("service off instruction boundary");
endmodule : external_edge_interrupt

// ===== eei_pin_model.sv
// Behavioural driver for the digital signal on the external interrupt pin.
`timescale 1ns/100ps
module eei_pin_model
    import eei_pkg::*;
(
    input wire logic clk,  // Core clock, paces the level changes.
    output logic extIrqPin // Level presented at the interrupt pin.
);
    // The pin idles low after power up, so the first rising edge is deliberate.
    initial extIrqPin = 1'b0;

    // Change the level after a chosen wait, then hold it well past the two-stage synchroniser.
    // Pulses narrower than one clock may be lost, so a level never stands less than six.
    task automatic drive(input logic lvl, input int waitCycles);
        repeat (waitCycles) @(posedge clk);
        extIrqPin <= lvl;
        repeat (6) @(posedge clk);
    endtask : drive
endmodule : eei_pin_model

// ===== external_edge_interrupt_bench.sv
// Self-checking bench for the external pin edge interrupt block.
`timescale 1ns/100ps
module external_edge_interrupt_bench import eei_pkg::*;;
    localparam logic [31:0] kFlag = 32'h0000_0001 << EEI_PIN_FLAG_BIT;
    localparam logic [31:0] kEn = 32'h0000_0001 << EEI_PIN_EN_BIT;
    localparam logic [31:0] kGlobal = 32'h0000_0001 << EEI_GLOBAL_EN_BIT;
    localparam logic [12:0] kPc = 13'h0abc;
    logic clk, reset_n, extIrqPin, sleepReq, retFromIrq, psel, penable, pwrite;
    logic [12:0] curPc, pcLoad, pushAddr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic pready, pslverr, irqReq, asleep, wakeUp, serviceStart, err;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    bit seen;

    external_edge_interrupt uut (.clk(clk), .reset_n(reset_n), .extIrqPin(extIrqPin),
        .sleepReq(sleepReq), .retFromIrq(retFromIrq), .curPc(curPc), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irqReq(irqReq), .asleep(asleep), .wakeUp(wakeUp),
        .serviceStart(serviceStart), .pcLoad(pcLoad), .pushAddr(pushAddr));
    eei_pin_model pin (.clk(clk), .extIrqPin(extIrqPin));

    // Free-running 20 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cut a hang short; the whole sequence needs well under a thousand cycles.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One APB transfer; nothing is released before pready is sampled high.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // The wait ends when pready is sampled high, or else at the bench timeout.
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic expectReg(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        check(name, exp, rdv);
    endtask : expectReg

    // Watch a bounded window for the wake pulse, which stands one cycle only.
    task automatic waitWake();
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge clk);
            if (wakeUp === 1'b1)
                seen = 1'b1;
        end
    endtask : waitWake

    task automatic pulseSleep();
        sleepReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
    endtask : pulseSleep

    task automatic conclude();
        $display("counts: %0d compared, %0d miscompares", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Main sequence: each test is a run of bus calls and pin events with expected values.
    initial
    begin
        {reset_n, sleepReq, retFromIrq, psel, penable, pwrite} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        curPc = kPc;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        expectReg("ctrl reset", EEI_CTRL_ADDR, {24'h00_0000, EEI_CTRL_RST});
        expectReg("cfg reset", EEI_CFG_ADDR, {30'h0000_0000, EEI_CFG_RST});
        expectReg("unmapped read", 8'h10, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
        $display("test reset and map done");
        // The pin is analog out of reset: it reads zero and edges are dropped.
        pin.drive(1'b1, 0);
        expectReg("analog pin level", EEI_STAT_ADDR, 32'h0000_0000);
        pin.drive(1'b0, 3);
        expectReg("analog no flag", EEI_CTRL_ADDR, 32'h0000_0000);
        $display("test analog pin done");
        // Digital, falling polarity: a rise is ignored, a fall sets the flag with all enables off.
        apb(EEI_CFG_ADDR, 1'b1, 32'h0000_0000);
        pin.drive(1'b1, 0);
        expectReg("rise ignored", EEI_CTRL_ADDR, 32'h0000_0000);
        expectReg("digital pin level", EEI_STAT_ADDR, 32'h0000_0001);
        pin.drive(1'b0, 2);
        expectReg("fall sets flag", EEI_CTRL_ADDR, kFlag);
        apb(EEI_CTRL_ADDR, 1'b1, 32'h0000_0000);
        expectReg("flag cleared", EEI_CTRL_ADDR, 32'h0000_0000);
        $display("test falling edge done");
        // Rising polarity, then the request held off until both enables are set.
        // The request is looked at mid-cycle, once the write has landed.
        apb(EEI_CFG_ADDR, 1'b1, 32'h0000_0001);
        pin.drive(1'b1, 0);
        expectReg("rise sets flag", EEI_CTRL_ADDR, kFlag);
        apb(EEI_CTRL_ADDR, 1'b1, kFlag | kGlobal);
        @(negedge clk);
        check("no request without enable", 32'h0000_0000, {31'h0000_0000, irqReq});
        apb(EEI_CTRL_ADDR, 1'b1, kFlag | kGlobal | kEn);
        @(negedge clk);
        check("request with all set", 32'h0000_0001, {31'h0000_0000, irqReq});
        // The counter starts one edge after the request, runs 9 to 12 clocks to the pulse,
        // and the pulse is sampled one edge after it rises.
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (serviceStart !== 1'b1 && n < 40);
        seen = (n >= 11) && (n <= 14);
        check("service latency ok", 32'h0000_0001, {31'h0000_0000, seen});
        check("vector", {19'h0_0000, EEI_VECTOR}, {19'h0_0000, pcLoad});
        check("pushed port", {19'h0_0000, kPc}, {19'h0_0000, pushAddr});
        expectReg("return address", EEI_CORE_ADDR, {19'h0_0000, kPc});
        expectReg("global cleared", EEI_CTRL_ADDR, kFlag | kEn);
        apb(EEI_CTRL_ADDR, 1'b1, kEn);
        retFromIrq <= 1'b1;
        @(posedge clk);
        retFromIrq <= 1'b0;
        expectReg("return sets global", EEI_CTRL_ADDR, kEn | kGlobal);
        $display("test service done");
        // Sleep with the enable set: a valid edge wakes the core.
        apb(EEI_CTRL_ADDR, 1'b1, kEn);
        pin.drive(1'b0, 0);
        pulseSleep();
        expectReg("asleep", EEI_STAT_ADDR, 32'h0000_0002);
        fork
            pin.drive(1'b1, 3);
            waitWake();
        join
        check("wake seen", 32'h0000_0001, {31'h0000_0000, seen});
        check("awake port", 32'h0000_0000, {31'h0000_0000, asleep});
        $display("test wake done");
        // Sleep with the enable clear: the edge still sets the flag but must not wake.
        apb(EEI_CTRL_ADDR, 1'b1, 32'h0000_0000);
        pin.drive(1'b0, 0);
        pulseSleep();
        fork
            pin.drive(1'b1, 1);
            waitWake();
        join
        check("no wake", 32'h0000_0000, {31'h0000_0000, seen});
        check("asleep port", 32'h0000_0001, {31'h0000_0000, asleep});
        expectReg("flag while masked", EEI_CTRL_ADDR, kFlag);
        $display("test masked sleep done");
        conclude();
    end
endmodule : external_edge_interrupt_bench
